/* File: hw/sgx_pkg.sv */
// Purpose: constants and types of the serial gpio expander
// Assumes: 10 MHz clk_in, two-wire bus sampled by that clock
// Notes:   offsets, reset values and cycle counts live here, save the blink half period in sgx_top
//
// Summary of operation
// (RQ1) answer address 0100 plus three select pins, bytes 40h to 4Eh
// (RQ2) catch the select pins after reset so eight parts share one bus
// (RQ3) accept byte-write and byte-read transactions on the two-wire bus
// (RQ4) master writes: address with direction 0, command byte, then data
// (RQ5) registers work in pairs; pointer flips to the partner after each write
// (RQ6) any number of written bytes, alternating within the pair
// (RQ7) master reads: command write, repeated start, address with direction 1
// (RQ8) each further read byte comes from the partner register, alternating
// (RQ9) master ends a read by not acknowledging the last byte
// (RQ10) read data is loaded on the falling clock of the acknowledge pulse
// (RQ11) reset puts every register and the bus machine in default state
// (RQ12) all 16 pins start as inputs; push-pull or open-drain selectable
// (RQ13) input pins have both drivers off, only the weak pull-up
// (RQ14) output pins drive the output register bit via high or low driver
// (RQ15) alert asserts when any input pin changes level
// (RQ16) alert clears when input returns or its input register is read
// (RQ17) output pins never cause an alert
// (RQ18) alert clearing tracked per port; one port read leaves other alone
// (RQ19) alert level or pulse; polarity 0 low-active, polarity 1 inverted
// (RQ20) blink or tone mode emits waveform while pin would be low
// (RQ21) clock and data inputs are filtered against short spikes
// (RQ22) bus works from static clock up to 400 kHz
// (RQ23) an alert pulse lasts 250 microseconds
// (RQ24) pulse mode pulses again on each further new input change
// (RQ25) alert function, type and polarity sit in register 10h
// (RQ26) input register shows real pin level for inputs and outputs
// (RQ27) acknowledge own address, command and data; ignore other targets
package sgx_pkg;
  // ----------------------------------------------------------------------
  // bus addressing and register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] I2C_ADDR_HIGH = 4'h4;
  localparam logic [7:0] REG_IN0       = 8'h00;
  localparam logic [7:0] REG_IN1       = 8'h01;
  localparam logic [7:0] REG_OUT0      = 8'h02;
  localparam logic [7:0] REG_OUT1      = 8'h03;
  localparam logic [7:0] REG_POL0      = 8'h04;
  localparam logic [7:0] REG_POL1      = 8'h05;
  localparam logic [7:0] REG_DIR0      = 8'h06;
  localparam logic [7:0] REG_DIR1      = 8'h07;
  localparam logic [7:0] REG_ALERT_CFG = 8'h10;
  localparam logic [7:0] REG_TYPE0     = 8'h12;
  localparam logic [7:0] REG_TYPE1     = 8'h13;
  localparam logic [7:0] PAIR_FLIP     = 8'h01;
  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] OUT_RST       = 8'hFF;
  localparam logic [7:0] POL_RST       = 8'h00;
  localparam logic [7:0] DIR_RST       = 8'hFF;
  localparam logic [7:0] TYPE_RST      = 8'hFF;
  localparam logic [7:0] ALERT_CFG_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // ----------------------------------------------------------------------
  // alert pin functions and timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] FUNC_INT  = 2'h0;
  localparam logic [1:0] FUNC_LED  = 2'h1;
  localparam logic [1:0] FUNC_BEEP = 2'h2;
  localparam int CLK_FREQ_KHZ       = 10000;
  localparam int ALERT_PULSE_US     = 250;
  localparam int ALERT_PULSE_CYCLES = (ALERT_PULSE_US * CLK_FREQ_KHZ) / 1000;
  localparam logic [11:0] PULSE_LOAD = 12'(ALERT_PULSE_CYCLES);
  localparam logic [11:0] TONE_HALF  = 12'h4E2;
  localparam logic [1:0]  STRAP_WAIT = 2'h3;
  localparam logic [3:0]  BITS_FULL  = 4'h8;
  localparam int FILTER_SAMPLES      = 2;

  typedef struct packed {
    logic [1:0] beep_sel;
    logic [1:0] led_sel;
    logic       invert;
    logic       pulse;
    logic [1:0] func;
  } sgx_alert_cfg_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } sgx_state_type;
endpackage

/* File: hw/sgx_filter.sv */
// Purpose: two-flop synchroniser and spike filter for one bus line
// Assumes: idle line level is high
// Notes:   output follows only after the line holds for SAMPLES clocks
`timescale 1ns/1ps
`default_nettype none
module sgx_filter
  import sgx_pkg::*;
#(
  parameter int SAMPLES = FILTER_SAMPLES
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic raw_in,
  output logic      clean_out
);
  logic       sync1_r;
  logic       sync2_r;
  logic [2:0] hold_cnt_r;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  // a level shorter than SAMPLES clocks never reaches the bus machine
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clean_out  <= 1'b1;
      hold_cnt_r <= 3'h0;
    end else if (sync2_r == clean_out) begin
      hold_cnt_r <= 3'h0;
    end else if (hold_cnt_r == 3'(SAMPLES - 1)) begin
      clean_out  <= sync2_r; // RQ21
      hold_cnt_r <= 3'h0;
    end else begin
      hold_cnt_r <= hold_cnt_r + 3'h1;
    end
  end
endmodule
`default_nettype wire

/* File: hw/sgx_top.sv */
// Purpose: 16-pin gpio expander behind a two-wire bus target
// Assumes: rst_b_in is the internal power-on reset; pins sampled by clk_in
// Notes:   scl low phase must span several clk_in cycles for the slave reply
`timescale 1ns/1ps
`default_nettype none
module sgx_top
  import sgx_pkg::*;
#(
  parameter int BLINK_HALF_CYCLES = 5000000
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_line_out,
  output logic             sda_oe_b_out,
  input  wire logic        addr_select_bit_zero_in,
  input  wire logic        addr_select_bit_one_in,
  input  wire logic        addr_select_bit_two_in,
  input  wire logic [15:0] gpio_pin_in,
  output logic      [15:0] gpio_pin_out,
  output logic      [15:0] gpio_pin_oe_b_out,
  output logic             alert_blink_tone_pin_out,
  output logic             alert_blink_tone_pin_oe_b_out
);
  localparam int BW = $clog2(BLINK_HALF_CYCLES + 1);

  // ----------------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------------
  logic [1:0]        bus_raw;
  logic [1:0]        bus_clean;
  logic              scl_q_r;
  logic              sda_q_r;
  logic              scl_rise;
  logic              scl_fall;
  logic              bus_start;
  logic              bus_stop;
  logic [15:0]       gpio_s1_r;
  logic [15:0]       gpio_s2_r;
  logic [2:0]        addr_s1_r;
  logic [2:0]        addr_s2_r;
  logic [1:0]        strap_cnt_r;
  logic              strap_done_r;
  logic [2:0]        dev_addr_r;

  assign bus_raw = {sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      sgx_filter u_filt (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .raw_in    (bus_raw[gi]),
        .clean_out (bus_clean[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= bus_clean[0];
      sda_q_r <= bus_clean[1];
    end
  end

  assign scl_rise  = bus_clean[0] & ~scl_q_r;
  assign scl_fall  = ~bus_clean[0] & scl_q_r;
  assign bus_start = strap_done_r & bus_clean[0] & scl_q_r & sda_q_r & ~bus_clean[1];
  assign bus_stop  = bus_clean[0] & scl_q_r & ~sda_q_r & bus_clean[1];

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gpio_s1_r <= 16'h0000;
      gpio_s2_r <= 16'h0000;
      addr_s1_r <= 3'h0;
      addr_s2_r <= 3'h0;
    end else begin
      gpio_s1_r <= gpio_pin_in;
      gpio_s2_r <= gpio_s1_r;
      addr_s1_r <= {addr_select_bit_two_in, addr_select_bit_one_in, addr_select_bit_zero_in};
      addr_s2_r <= addr_s1_r;
    end
  end

  // straps are caught once the synchroniser has filled after release
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_cnt_r  <= 2'h0;
      strap_done_r <= 1'b0;
      dev_addr_r   <= 3'h0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == STRAP_WAIT) begin
        dev_addr_r   <= addr_s2_r; // RQ2
        strap_done_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [1:0][7:0]   out_r;
  logic [1:0][7:0]   pol_r;
  logic [1:0][7:0]   dir_r;
  logic [1:0][7:0]   type_r;
  sgx_alert_cfg_type acfg_r;
  logic [15:0]       out_vec;
  logic [15:0]       dir_vec;
  logic [15:0]       in_val;
  logic [15:0]       high_side_driver;
  logic [15:0]       low_side_driver;
  sgx_state_type     st_r;
  logic [3:0]        bitcnt_r;
  logic [7:0]        shift_r;
  logic [7:0]        ptr_r;
  logic [7:0]        tx_r;
  logic              rw_r;
  logic              nack_r;
  logic              sda_low_r;
  logic              wr_en;
  logic              rd_take;
  logic [7:0]        rd_idx;
  logic [7:0]        rd_data;
  logic              addr_hit;

  assign out_vec = {out_r[1], out_r[0]};
  assign dir_vec = {dir_r[1], dir_r[0]};
  assign in_val  = gpio_s2_r ^ {pol_r[1], pol_r[0]}; // RQ26

  always_comb begin
    rd_data = UNMAPPED_READ;
    if (rd_idx == REG_IN0) begin
      rd_data = in_val[7:0];
    end else if (rd_idx == REG_IN1) begin
      rd_data = in_val[15:8];
    end else if (rd_idx == REG_OUT0) begin
      rd_data = out_r[0];
    end else if (rd_idx == REG_OUT1) begin
      rd_data = out_r[1];
    end else if (rd_idx == REG_POL0) begin
      rd_data = pol_r[0];
    end else if (rd_idx == REG_POL1) begin
      rd_data = pol_r[1];
    end else if (rd_idx == REG_DIR0) begin
      rd_data = dir_r[0];
    end else if (rd_idx == REG_DIR1) begin
      rd_data = dir_r[1];
    end else if (rd_idx == REG_ALERT_CFG) begin
      rd_data = acfg_r;
    end else if (rd_idx == REG_TYPE0) begin
      rd_data = type_r[0];
    end else if (rd_idx == REG_TYPE1) begin
      rd_data = type_r[1];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_r  <= {OUT_RST, OUT_RST}; // RQ11
      pol_r  <= {POL_RST, POL_RST};
      dir_r  <= {DIR_RST, DIR_RST}; // RQ12
      type_r <= {TYPE_RST, TYPE_RST};
      acfg_r <= ALERT_CFG_RST;
    end else if (wr_en) begin
      if (ptr_r == REG_OUT0) begin
        out_r[0] <= shift_r;
      end else if (ptr_r == REG_OUT1) begin
        out_r[1] <= shift_r;
      end else if (ptr_r == REG_POL0) begin
        pol_r[0] <= shift_r;
      end else if (ptr_r == REG_POL1) begin
        pol_r[1] <= shift_r;
      end else if (ptr_r == REG_DIR0) begin
        dir_r[0] <= shift_r;
      end else if (ptr_r == REG_DIR1) begin
        dir_r[1] <= shift_r;
      end else if (ptr_r == REG_ALERT_CFG) begin
        acfg_r <= shift_r; // RQ25
      end else if (ptr_r == REG_TYPE0) begin
        type_r[0] <= shift_r;
      end else if (ptr_r == REG_TYPE1) begin
        type_r[1] <= shift_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // bus target state machine
  // ----------------------------------------------------------------------
  assign addr_hit = (shift_r[7:1] == {I2C_ADDR_HIGH, dev_addr_r}); // RQ1
  assign wr_en    = (st_r == ST_WDATA) && scl_fall && (bitcnt_r == BITS_FULL);
  assign rd_take  = scl_fall && (((st_r == ST_ADDR_ACK) && rw_r) || ((st_r == ST_RACK) && !nack_r));
  assign rd_idx   = (st_r == ST_RACK) ? (ptr_r ^ PAIR_FLIP) : ptr_r; // RQ8

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r      <= ST_IDLE; // RQ11
      bitcnt_r  <= 4'h0;
      shift_r   <= 8'h00;
      ptr_r     <= 8'h00;
      tx_r      <= 8'h00;
      rw_r      <= 1'b0;
      nack_r    <= 1'b0;
      sda_low_r <= 1'b0;
    end else if (bus_stop) begin
      st_r      <= ST_IDLE; // RQ3
      sda_low_r <= 1'b0;
    end else if (bus_start) begin
      st_r      <= ST_ADDR; // RQ7
      bitcnt_r  <= 4'h0;
      sda_low_r <= 1'b0;
    // no bus timeout anywhere, so a stalled or slow clock just parks the machine
    end else if (scl_rise) begin // RQ22
      if (st_r == ST_ADDR || st_r == ST_CMD || st_r == ST_WDATA) begin
        shift_r  <= {shift_r[6:0], bus_clean[1]};
        bitcnt_r <= bitcnt_r + 4'h1;
      end else if (st_r == ST_RDATA) begin
        bitcnt_r <= bitcnt_r + 4'h1;
      end else if (st_r == ST_RACK) begin
        nack_r <= bus_clean[1]; // RQ9
      end
    end else if (scl_fall) begin
      case (st_r)
        ST_ADDR: begin
          if (bitcnt_r == BITS_FULL) begin
            if (addr_hit) begin
              st_r      <= ST_ADDR_ACK; // RQ27
              rw_r      <= shift_r[0];
              sda_low_r <= 1'b1;
            end else begin
              st_r <= ST_IDLE; // RQ27
            end
          end
        end
        ST_ADDR_ACK: begin
          bitcnt_r <= 4'h0;
          if (rw_r) begin
            st_r      <= ST_RDATA;
            tx_r      <= rd_data; // RQ10
            sda_low_r <= ~rd_data[7];
          end else begin
            st_r      <= ST_CMD; // RQ4
            sda_low_r <= 1'b0;
          end
        end
        ST_CMD: begin
          if (bitcnt_r == BITS_FULL) begin
            ptr_r     <= shift_r;
            st_r      <= ST_CMD_ACK;
            sda_low_r <= 1'b1; // RQ27
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK: begin
          st_r      <= ST_WDATA;
          bitcnt_r  <= 4'h0;
          sda_low_r <= 1'b0;
        end
        ST_WDATA: begin
          if (bitcnt_r == BITS_FULL) begin
            ptr_r     <= ptr_r ^ PAIR_FLIP; // RQ5 RQ6
            st_r      <= ST_WDATA_ACK;
            sda_low_r <= 1'b1;
          end
        end
        ST_RDATA: begin
          if (bitcnt_r == BITS_FULL) begin
            st_r      <= ST_RACK;
            sda_low_r <= 1'b0;
          end else begin
            tx_r      <= {tx_r[6:0], 1'b0};
            sda_low_r <= ~tx_r[6];
          end
        end
        ST_RACK: begin
          bitcnt_r <= 4'h0;
          if (nack_r) begin
            st_r <= ST_IDLE; // RQ9
          end else begin
            st_r      <= ST_RDATA;
            ptr_r     <= rd_idx; // RQ8
            tx_r      <= rd_data; // RQ10
            sda_low_r <= ~rd_data[7];
          end
        end
        default: begin
          sda_low_r <= 1'b0;
        end
      endcase
    end
  end

  assign sda_line_out = 1'b0;
  assign sda_oe_b_out = ~sda_low_r;

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  assign high_side_driver  = ~dir_vec & out_vec & {type_r[1], type_r[0]}; // RQ12 RQ14
  assign low_side_driver   = ~dir_vec & ~out_vec; // RQ14
  assign gpio_pin_out      = out_vec;
  assign gpio_pin_oe_b_out = ~(high_side_driver | low_side_driver); // RQ13

  // ----------------------------------------------------------------------
  // change alert
  // ----------------------------------------------------------------------
  logic [15:0]   snap_r;
  logic [15:0]   mism;
  logic [15:0]   mism_q_r;
  logic          new_ev;
  logic [11:0]   pulse_cnt_r;
  logic          alert_active;
  logic          int_val;
  logic [BW-1:0] blink_cnt_r;
  logic          blink_r;
  logic [11:0]   tone_cnt_r;
  logic          tone_r;

  // quiet until the straps settle, else the synchroniser reset value looks like a change
  assign mism   = {16{strap_done_r}} & dir_vec & (gpio_s2_r ^ snap_r); // RQ15 RQ17
  assign new_ev = |(mism & ~mism_q_r);

  // output pins keep their snapshot current, so a later turn to input is quiet
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      snap_r   <= 16'h0000;
      mism_q_r <= 16'h0000;
    end else begin
      mism_q_r <= mism;
      if (!strap_done_r) begin
        snap_r <= gpio_s2_r;
      end else begin
        snap_r <= (snap_r & dir_vec) | (gpio_s2_r & ~dir_vec);
        if (rd_take && rd_idx == REG_IN0) begin
          snap_r[7:0] <= gpio_s2_r[7:0]; // RQ16 RQ18
        end else if (rd_take && rd_idx == REG_IN1) begin
          snap_r[15:8] <= gpio_s2_r[15:8]; // RQ16 RQ18
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pulse_cnt_r <= 12'h000;
    end else if (new_ev && acfg_r.pulse) begin
      pulse_cnt_r <= PULSE_LOAD; // RQ23 RQ24
    end else if (pulse_cnt_r != 12'h000) begin
      pulse_cnt_r <= pulse_cnt_r - 12'h001;
    end
  end

  // blink and tone run free; only the gating follows the alert
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      blink_cnt_r <= '0;
      blink_r     <= 1'b0;
      tone_cnt_r  <= 12'h000;
      tone_r      <= 1'b0;
    end else begin
      blink_cnt_r <= blink_cnt_r + 1'b1;
      tone_cnt_r  <= tone_cnt_r + 12'h001;
      if (blink_cnt_r == BW'(BLINK_HALF_CYCLES - 1)) begin
        blink_cnt_r <= '0;
        blink_r     <= ~blink_r;
      end
      if (tone_cnt_r == TONE_HALF - 12'h001) begin
        tone_cnt_r <= 12'h000;
        tone_r     <= ~tone_r;
      end
    end
  end

  assign alert_active = acfg_r.pulse ? (pulse_cnt_r != 12'h000) : (|mism);
  assign int_val      = acfg_r.invert ? alert_active : ~alert_active; // RQ19

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      alert_blink_tone_pin_out      <= 1'b1;
      alert_blink_tone_pin_oe_b_out <= 1'b1;
    end else if (acfg_r.func == FUNC_LED) begin
      alert_blink_tone_pin_out      <= int_val | ((acfg_r.led_sel != 2'h0) & blink_r); // RQ20
      alert_blink_tone_pin_oe_b_out <= 1'b0;
    end else if (acfg_r.func == FUNC_BEEP) begin
      alert_blink_tone_pin_out      <= int_val | ((acfg_r.beep_sel != 2'h0) & tone_r); // RQ20
      alert_blink_tone_pin_oe_b_out <= 1'b0;
    end else begin
      alert_blink_tone_pin_out      <= int_val;
      alert_blink_tone_pin_oe_b_out <= int_val; // RQ19
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_addr_done;
    !bus_stop && !bus_start && st_r == ST_ADDR && scl_fall && bitcnt_r == BITS_FULL;
  endsequence
  sequence s_level_int;
    acfg_r.func == FUNC_INT && !acfg_r.pulse && !acfg_r.invert;
  endsequence

  a_addr_own_ack: assert property (s_addr_done ##0 addr_hit |=> st_r == ST_ADDR_ACK && !sda_oe_b_out) // RQ1
    else $error("own address not acknowledged");
  a_addr_other_drop: assert property (s_addr_done ##0 !addr_hit |=> st_r == ST_IDLE && sda_oe_b_out) // RQ27
    else $error("foreign address not ignored");
  a_write_pair_flip: assert property (wr_en && !bus_stop |=> ptr_r == ($past(ptr_r) ^ PAIR_FLIP)) // RQ5
    else $error("pointer did not flip after write");
  a_read_load: assert property (rd_take && !bus_stop && !bus_start |=> tx_r == $past(rd_data)) // RQ10
    else $error("read byte not loaded at ack fall");
  a_port0_clear: assert property (rd_take && rd_idx == REG_IN0 && strap_done_r
    |=> snap_r[7:0] == $past(gpio_s2_r[7:0]) && ((snap_r[15:8] ^ $past(snap_r[15:8])) & $past(dir_vec[15:8])) == 8'h00) // RQ18
    else $error("port read cleared wrong port");
  a_input_hiz: assert property ((gpio_pin_oe_b_out | ~dir_vec) == 16'hFFFF) // RQ13
    else $error("input pin driven");
  a_output_low: assert property ((~gpio_pin_oe_b_out | dir_vec | out_vec) == 16'hFFFF) // RQ14
    else $error("output zero not driven");
  a_level_alert: assert property (s_level_int ##0 $rose(|mism) |=> !alert_blink_tone_pin_out [*2]) // RQ15
    else $error("alert missing on input change");
  a_output_quiet: assert property (s_level_int ##0 mism == 16'h0000 |=> alert_blink_tone_pin_out) // RQ17
    else $error("alert without input change");
  a_pulse_len: assert property (new_ev && acfg_r.pulse |=> pulse_cnt_r == PULSE_LOAD) // RQ23
    else $error("pulse length wrong");
  a_pulse_end: assert property (pulse_cnt_r == 12'h001 && !(new_ev && acfg_r.pulse) |=> pulse_cnt_r == 12'h000) // RQ23
    else $error("pulse did not end");
  a_stop_idle: assert property (bus_stop |=> st_r == ST_IDLE && sda_oe_b_out) // RQ3
    else $error("stop did not idle bus");
endmodule
`default_nettype wire

/* File: bench/sgx_master.sv */
// Purpose: two-wire bus master model facing the expander
// Assumes: lines pulled up; steps taken at falling clk_in
// Notes:   scl 500 ns low, 300 ns high; scl stands still between frames
`timescale 1ns/1ps
`default_nettype none
module sgx_master (
  input  wire logic clk_in,
  input  wire logic dev_oe_b_in,
  input  wire logic dev_line_in,
  output logic      scl_out,
  output logic      sda_out
);
  logic m_sda = 1'h1;
  initial scl_out = 1'h1;
  // wired-and with pull-up, so a released line reads high
  assign sda_out = m_sda & (dev_oe_b_in | dev_line_in);
  // ----------------------------------------------------------------------
  // bit and frame steps
  // ----------------------------------------------------------------------
  task automatic tk(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic bx(input logic b, output logic r);
    scl_out = 1'h0;
    tk(1);
    m_sda = b;
    tk(4);
    scl_out = 1'h1;
    tk(2);
    r = sda_out; // sampled late in the high phase, after the slave reply settles
    tk(1);
  endtask
  // a then b while scl high: (1,0) start or repeated start, (0,1) stop
  task automatic fr(input logic a, input logic b);
    scl_out = 1'h0;
    tk(1);
    m_sda = a;
    tk(4);
    scl_out = 1'h1;
    tk(3);
    m_sda = b;
    tk(3);
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bx(d[i], r);
    bx(1'h1, r);
    ack = ~r;
  endtask
  // ----------------------------------------------------------------------
  // transactions
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] c, input int n, input logic [23:0] d, output logic ok);
    logic k;
    fr(1'h1, 1'h0);
    wb({a[7:1], 1'h0}, ok);
    wb(c, k);
    ok &= k;
    for (int i = n - 1; i >= 0; i--) begin
      wb(d[8*i +: 8], k);
      ok &= k;
    end
    fr(1'h0, 1'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] c, input int n, output logic [23:0] q);
    logic k;
    q = 24'h0;
    fr(1'h1, 1'h0);
    wb({a[7:1], 1'h0}, k);
    wb(c, k);
    fr(1'h1, 1'h0);
    wb({a[7:1], 1'h1}, k);
    for (int i = n - 1; i >= 0; i--) begin
      for (int j = 7; j >= 0; j--) bx(1'h1, q[8*i+j]);
      bx(i == 0, k);
    end
    fr(1'h0, 1'h1);
  endtask
endmodule
`default_nettype wire

/* File: bench/sgx_tb_top.sv */
// Purpose: self-checking bench for the serial gpio expander
// Assumes: 10 MHz clk_in; straps 101 at reset give address 4Ah
// Notes:   blink half period cut to 20 clocks to keep the run short
`timescale 1ns/1ps
`default_nettype none
module sgx_tb_top;
  import sgx_pkg::*;
  logic        clk_in = 1'h0;
  logic        rst_b_in = 1'h0;
  logic        scl, sda, sda_oe_b, sda_line, alrt, alrt_oe_b, ok;
  logic [2:0]  strap = 3'h5;
  logic [15:0] ext = 16'hFFFF;
  logic [15:0] pin_out, pin_oe_b, pins;
  logic [23:0] q;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #50 clk_in = ~clk_in;
  // pin wire: driven level where enabled, else the outside world
  assign pins = (~pin_oe_b & pin_out) | (pin_oe_b & ext);
  sgx_top #(.BLINK_HALF_CYCLES(20)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda),
    .sda_line_out(sda_line), .sda_oe_b_out(sda_oe_b), .addr_select_bit_zero_in(strap[0]),
    .addr_select_bit_one_in(strap[1]), .addr_select_bit_two_in(strap[2]), .gpio_pin_in(pins),
    .gpio_pin_out(pin_out), .gpio_pin_oe_b_out(pin_oe_b), .alert_blink_tone_pin_out(alrt),
    .alert_blink_tone_pin_oe_b_out(alrt_oe_b));
  sgx_master m (.clk_in(clk_in), .dev_oe_b_in(sda_oe_b), .dev_line_in(sda_line), .scl_out(scl), .sda_out(sda));
  // ----------------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // about 10k cycles expected, well short of the budget; a hang is stopped at 30000 cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_wr(input logic [7:0] c, input int n, input logic [23:0] d);
    m.wr(8'h4A, c, n, d, ok);
    chk(ok, 24'h1);
  endtask
  task automatic t_reset;
    chk({pin_out, pin_oe_b}, {16'hFFFF, 16'hFFFF});
    chk({sda_oe_b, alrt, alrt_oe_b}, 24'h7);
  endtask
  task automatic t_pairs;
    m.wr(8'h40, REG_OUT0, 1, 24'h0, ok);
    chk(ok, 24'h0);
    t_wr(REG_OUT1, 3, 24'h0FAA33);
    chk(pin_out, 24'h33AA);
    t_wr(REG_DIR0, 2, 24'h00FF);
    chk(pin_oe_b, 24'hFF00);
    t_wr(REG_TYPE0, 1, 24'h0F);
    chk(pin_oe_b, 24'hFFA0);
    m.rd(8'h4A, REG_OUT1, 3, q);
    chk(q, 24'h33AA33);
    m.rd(8'h4A, REG_IN0, 2, q);
    chk(q, 24'hAAFF);
  endtask
  task automatic t_level;
    ext[5] = 1'h0;
    m.tk(20);
    chk(alrt, 24'h1);
    ext[9] = 1'h0;
    m.tk(10);
    chk(alrt, 24'h0);
    m.rd(8'h4A, REG_IN0, 1, q);
    chk(alrt, 24'h0);
    m.rd(8'h4A, REG_IN1, 1, q);
    chk({q[7:0], alrt}, {8'hFD, 1'h1});
    ext[9] = 1'h1;
    m.tk(10);
    chk(alrt, 24'h0);
    ext[9] = 1'h0;
    m.tk(10);
    chk(alrt, 24'h1);
    t_wr(REG_ALERT_CFG, 1, 24'h08);
    ext[10] = 1'h0;
    m.tk(10);
    chk(alrt, 24'h1);
  endtask
  task automatic t_pulse;
    logic s0, s1;
    m.rd(8'h4A, REG_IN1, 1, q);
    t_wr(REG_ALERT_CFG, 1, 24'h04);
    ext[11] = 1'h0;
    m.tk(100);
    chk(alrt, 24'h0);
    m.tk(2350);
    chk(alrt, 24'h0);
    m.tk(150);
    chk(alrt, 24'h1);
    ext[12] = 1'h0;
    m.tk(10);
    chk(alrt, 24'h0);
    m.tk(2600);
    t_wr(REG_ALERT_CFG, 1, 24'h11);
    {s0, s1} = 2'h0;
    repeat (60) begin
      m.tk(1);
      s0 |= (alrt === 1'h0);
      s1 |= (alrt === 1'h1);
    end
    chk({s0, s1, alrt_oe_b}, 24'h6);
  endtask
  task automatic t_restrap;
    ext = 16'h1220;
    m.tk(10);
    chk(alrt, 24'h0);
    m.wr(8'h4A, REG_OUT0, 1, 24'h0, ok);
    chk(ok, 24'h0);
    m.rd(8'h44, REG_IN1, 2, q);
    chk({q[15:0], alrt}, {16'h1220, 1'h1});
  endtask
  initial begin
    m.tk(10);
    rst_b_in = 1'h1;
    m.tk(10);
    strap = 3'h2;
    t_reset();
    t_pairs();
    t_level();
    t_pulse();
    rst_b_in = 1'h0;
    m.tk(2);
    rst_b_in = 1'h1;
    m.tk(10);
    t_reset();
    t_restrap();
    wrap_up();
  end
endmodule
`default_nettype wire
